// ==== design/scp_consts.vh ====
/*
 * Constants of the subchannel bit processor: register map, field layout,
 * reset values and frame timing.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef SCP_CONSTS_VH
`define SCP_CONSTS_VH

// Register byte addresses on the AXI4-Lite slave
`define SCP_ADDR_TX_CFG 8'h00
`define SCP_ADDR_RX_CFG 8'h04
`define SCP_ADDR_MSK_IDX 8'h08
`define SCP_ADDR_MSK_VAL 8'h0C
`define SCP_ADDR_STATUS 8'h10
`define SCP_ADDR_TX_DATA 8'h14
`define SCP_ADDR_RX_DATA 8'h18
`define SCP_ADDR_CTRL 8'h1C

// Bitfield config layout: count [2:0], start [5:3], transparent select [6]
`define SCP_CNT_LSB 0
`define SCP_CNT_MSB 2
`define SCP_START_LSB 3
`define SCP_START_MSB 5
`define SCP_TRP_BIT 6
`define SCP_CFG_W 7
`define SCP_CFG_RST 7'h00

// Mask index layout: channel [2:0], direction [3] (0 = transmit)
`define SCP_IDX_W 4
`define SCP_IDX_DIR_BIT 3
`define SCP_MASK_RST 8'h00

// Control: bit 0 enables frame processing
`define SCP_CTRL_EN_BIT 0

// Frame period of 125 us at a 5 ns clock
`define SCP_FRAME_NS 125000
`define SCP_CLK_NS 5

// AXI responses
`define SCP_RESP_OKAY 2'b00
`define SCP_RESP_SLVERR 2'b10

`endif

// ==== design/scp_fifo.v ====
/*
 * Synchronous FIFO with valid/ready on both sides, width and depth set
 * by parameters; depth must be a power of two.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none

module scp_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire mclk_i, // Clock
	input wire rst_i, // Sync reset
	input wire [WIDTH-1:0] in_data_i, // Write data
	input wire in_valid_i, // Write offered
	output wire in_ready_o, // Not full
	output wire [WIDTH-1:0] out_data_o, // Head word
	output wire out_valid_o, // Not empty
	input wire out_ready_i, // Pop
	output wire [AW:0] level_o // Fill level
);
	reg [WIDTH-1:0] mem_q [0:DEPTH-1];
	reg [AW:0] wr_q;
	reg [AW:0] rd_q;
	wire full;
	wire empty;
	wire push;
	wire pop;

	// Extra pointer bit tells full from empty
	assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
	assign empty = (wr_q == rd_q);
	assign push = in_valid_i && !full;
	assign pop = out_ready_i && !empty;
	assign in_ready_o = !full;
	assign out_valid_o = !empty;
	assign out_data_o = mem_q[rd_q[AW-1:0]];
	assign level_o = wr_q - rd_q;

	// Storage write, no reset needed on data
	always @(posedge mclk_i) begin
		if (push) begin
			mem_q[wr_q[AW-1:0]] <= in_data_i;
		end
	end

	// Pointers
	always @(posedge mclk_i) begin
		if (rst_i) begin
			wr_q <= {(AW+1){1'b0}};
			rd_q <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
		end
	end
endmodule

`default_nettype wire

// ==== design/scp_subchannel.v ====
/*
 * Subchannel bit processor for one transmit FIFO and eight channel masks.
 * Transmit: FIFO bits inserted into the channel mask byte each frame.
 * Receive: channel byte shifted down, field handed to the controller.
 * Assumes an AXI4-Lite master, a 200 MHz clock and a line side that
 * takes tx_byte_o on each frame strobe and offers rx_byte_i with it.
 */
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "scp_consts.vh"

//////////////////////////////////////////////////////////////////////////////
module scp_subchannel #(
	parameter FRAME_CYC = `SCP_FRAME_NS / `SCP_CLK_NS,
	parameter FIFO_DEPTH = 8,
	parameter FIFO_AW = 3
) (
	input wire mclk_i, // Clock 200 MHz
	input wire rst_i, // Sync reset, high
	input wire [7:0] s_axi_awaddr, // Write address
	input wire s_axi_awvalid, // Write address valid
	output reg s_axi_awready, // Write address ready
	input wire [31:0] s_axi_wdata, // Write data
	input wire [3:0] s_axi_wstrb, // Byte strobes
	input wire s_axi_wvalid, // Write data valid
	output reg s_axi_wready, // Write data ready
	output reg [1:0] s_axi_bresp, // Write response
	output reg s_axi_bvalid, // Write response valid
	input wire s_axi_bready, // Write response ready
	input wire [7:0] s_axi_araddr, // Read address
	input wire s_axi_arvalid, // Read address valid
	output reg s_axi_arready, // Read address ready
	output reg [31:0] s_axi_rdata, // Read data
	output reg [1:0] s_axi_rresp, // Read response
	output reg s_axi_rvalid, // Read data valid
	input wire s_axi_rready, // Read data ready
	input wire [2:0] tx_chan_i, // Channel whose mask is used
	input wire [7:0] rx_byte_i, // Received channel byte
	output reg [7:0] tx_byte_o, // Transmitted channel byte
	output reg frame_o, // Frame strobe, one cycle
	output reg [7:0] rx_field_o, // Aligned receive field
	output reg [3:0] rx_bits_o, // Valid bits in rx_field_o
	output reg rx_valid_o // Receive field strobe
);
	localparam ST_IDLE = 3'b001;
	localparam ST_LOAD = 3'b010;
	localparam ST_EMIT = 3'b100;

	reg [`SCP_CFG_W-1:0] tx_cfg_q;
	reg [`SCP_CFG_W-1:0] rx_cfg_q;
	reg [`SCP_IDX_W-1:0] idx_q;
	reg [7:0] mask_q [0:7];
	reg en_q;
	reg [31:0] frm_cnt_q;
	reg frame_tick;
	reg [2:0] st_q;
	reg [15:0] sh_q;
	reg [4:0] sh_n_q;
	reg underrun_q;
	reg [31:0] aw_q;
	reg aw_have_q;
	reg [31:0] wd_q;
	reg [3:0] ws_q;
	reg w_have_q;
	wire [7:0] ff_data;
	wire ff_valid;
	wire ff_in_ready;
	wire [FIFO_AW:0] ff_level;
	reg ff_pop;
	reg ff_push;
	reg [7:0] ff_push_data;
	reg [7:0] tx_field;
	reg [3:0] tx_need;
	reg [7:0] fill;
	reg [7:0] rx_sh;
	reg [3:0] lvl_ext;

	// Count of bits per frame; zero means a whole byte
	function [3:0] bit_count;
		input [`SCP_CFG_W-1:0] cfg;
		begin
			if (cfg[`SCP_CNT_MSB:`SCP_CNT_LSB] == 3'h0) begin
				bit_count = 4'h8;
			end else begin
				bit_count = {1'b0, cfg[`SCP_CNT_MSB:`SCP_CNT_LSB]};
			end
		end
	endfunction

	// Low-bit mask of n bits
	function [7:0] low_mask;
		input [3:0] n;
		begin
			low_mask = ~(8'hFF << n);
		end
	endfunction

	//////////////////////////////////////////////////////////////////////////
	// Transmit data buffer, filled by software, drained by frames
	scp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.in_data_i(ff_push_data),
		.in_valid_i(ff_push),
		.in_ready_o(ff_in_ready),
		.out_data_o(ff_data),
		.out_valid_o(ff_valid),
		.out_ready_i(ff_pop),
		.level_o(ff_level)
	);

	//////////////////////////////////////////////////////////////////////////
	// Frame divider: one enable pulse every 125 us
	always @(posedge mclk_i) begin
		if (rst_i || !en_q) begin
			frm_cnt_q <= 32'h0;
			frame_tick <= 1'b0;
		end else if (frm_cnt_q == FRAME_CYC - 1) begin
			frm_cnt_q <= 32'h0;
			frame_tick <= 1'b1;
		end else begin
			frm_cnt_q <= frm_cnt_q + 32'h1;
			frame_tick <= 1'b0;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Transmit byte build: tx settings only, independent of rx
	always @* begin
		tx_need = tx_cfg_q[`SCP_TRP_BIT] ? 4'h8 : bit_count(tx_cfg_q);
		// Transparent takes the low count bits of one byte; HDLC takes
		// the next count bits of the bit stream
		tx_field = sh_q[7:0] & low_mask(bit_count(tx_cfg_q));
		fill = low_mask(bit_count(tx_cfg_q)) << tx_cfg_q[`SCP_START_MSB:`SCP_START_LSB];
	end

	// Sequencer: load FIFO bits into the shifter, then emit on the frame.
	// Holding bits across frames spreads a byte LSB first (HDLC).
	always @(posedge mclk_i) begin
		ff_pop <= 1'b0;
		if (rst_i) begin
			st_q <= ST_IDLE;
			sh_q <= 16'h0;
			sh_n_q <= 5'h0;
			underrun_q <= 1'b0;
			tx_byte_o <= `SCP_MASK_RST;
			frame_o <= 1'b0;
		end else begin
			frame_o <= 1'b0;
			case (st_q)
				ST_IDLE: begin
					if (frame_tick) begin
						st_q <= ST_LOAD;
					end
				end
				ST_LOAD: begin
					// Top up until enough bits; one byte per pass
					if (sh_n_q < {1'b0, tx_need} && ff_valid && !ff_pop) begin
						sh_q <= sh_q | ({8'h00, ff_data} << sh_n_q[3:0]);
						sh_n_q <= sh_n_q + 5'h8;
						ff_pop <= 1'b1;
					end else if (!ff_pop) begin
						st_q <= ST_EMIT;
					end
				end
				ST_EMIT: begin
					// Mask bits outside the field pass unchanged
					tx_byte_o <= (mask_q[tx_chan_i] & ~fill) |
						((tx_field << tx_cfg_q[`SCP_START_MSB:`SCP_START_LSB]) & fill);
					frame_o <= 1'b1;
					if (sh_n_q < {1'b0, tx_need}) begin
						underrun_q <= 1'b1;
						sh_q <= 16'h0;
						sh_n_q <= 5'h0;
					end else if (tx_cfg_q[`SCP_TRP_BIT]) begin
						// Transparent drops the unused upper FIFO bits
						sh_q <= sh_q >> 8;
						sh_n_q <= sh_n_q - 5'h8;
					end else begin
						sh_q <= sh_q >> tx_need;
						sh_n_q <= sh_n_q - {1'b0, tx_need};
					end
					st_q <= ST_IDLE;
				end
				default: begin
					st_q <= ST_IDLE;
				end
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Receive: shift down by start; HDLC keeps only the field
	always @* begin
		rx_sh = rx_byte_i >> rx_cfg_q[`SCP_START_MSB:`SCP_START_LSB];
	end

	// Fill level widened to the status nibble; avoids a zero-width pad
	always @* begin
		lvl_ext = 4'h0;
		lvl_ext[FIFO_AW:0] = ff_level;
	end

	always @(posedge mclk_i) begin
		if (rst_i) begin
			rx_field_o <= 8'h00;
			rx_bits_o <= 4'h0;
			rx_valid_o <= 1'b0;
		end else begin
			rx_valid_o <= frame_tick;
			if (frame_tick) begin
				if (rx_cfg_q[`SCP_TRP_BIT]) begin
					rx_field_o <= rx_sh;
					rx_bits_o <= 4'h8;
				end else begin
					rx_field_o <= rx_sh & low_mask(bit_count(rx_cfg_q));
					rx_bits_o <= bit_count(rx_cfg_q);
				end
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write: address and data in either order, then response
	always @* begin
		ff_push = 1'b0;
		ff_push_data = wd_q[7:0];
		if (aw_have_q && w_have_q && !s_axi_bvalid &&
			aw_q[7:0] == `SCP_ADDR_TX_DATA && ws_q[0]) begin
			ff_push = 1'b1;
		end
	end

	always @(posedge mclk_i) begin
		if (rst_i) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `SCP_RESP_OKAY;
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_q <= 32'h0;
			wd_q <= 32'h0;
			ws_q <= 4'h0;
			tx_cfg_q <= `SCP_CFG_RST;
			rx_cfg_q <= `SCP_CFG_RST;
			idx_q <= {`SCP_IDX_W{1'b0}};
			en_q <= 1'b0;
		end else begin
			s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !w_have_q && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_q <= {24'h0, s_axi_awaddr};
				aw_have_q <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wd_q <= s_axi_wdata;
				ws_q <= s_axi_wstrb;
				w_have_q <= 1'b1;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			// Both halves held: commit once; a full buffer stalls the response
			if (aw_have_q && w_have_q && !s_axi_bvalid &&
				(aw_q[7:0] != `SCP_ADDR_TX_DATA || ff_in_ready || !ws_q[0])) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `SCP_RESP_OKAY;
				case (aw_q[7:0])
					`SCP_ADDR_TX_CFG: begin
						if (ws_q[0]) tx_cfg_q <= wd_q[`SCP_CFG_W-1:0];
					end
					`SCP_ADDR_RX_CFG: begin
						if (ws_q[0]) rx_cfg_q <= wd_q[`SCP_CFG_W-1:0];
					end
					`SCP_ADDR_MSK_IDX: begin
						if (ws_q[0]) idx_q <= wd_q[`SCP_IDX_W-1:0];
					end
					`SCP_ADDR_MSK_VAL, `SCP_ADDR_TX_DATA: begin
					end
					`SCP_ADDR_CTRL: begin
						if (ws_q[0]) en_q <= wd_q[`SCP_CTRL_EN_BIT];
					end
					default: begin
						s_axi_bresp <= `SCP_RESP_SLVERR;
					end
				endcase
			end
		end
	end

	// Mask array: written at the index chosen beforehand; tx masks only
	always @(posedge mclk_i) begin
		if (rst_i) begin
			mask_q[0] <= `SCP_MASK_RST;
			mask_q[1] <= `SCP_MASK_RST;
			mask_q[2] <= `SCP_MASK_RST;
			mask_q[3] <= `SCP_MASK_RST;
			mask_q[4] <= `SCP_MASK_RST;
			mask_q[5] <= `SCP_MASK_RST;
			mask_q[6] <= `SCP_MASK_RST;
			mask_q[7] <= `SCP_MASK_RST;
		end else if (aw_have_q && w_have_q && !s_axi_bvalid && ws_q[0] &&
			aw_q[7:0] == `SCP_ADDR_MSK_VAL && !idx_q[`SCP_IDX_DIR_BIT]) begin
			mask_q[idx_q[2:0]] <= wd_q[7:0];
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read: one cycle accept, data next cycle
	always @(posedge mclk_i) begin
		if (rst_i) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `SCP_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `SCP_RESP_OKAY;
				case (s_axi_araddr)
					`SCP_ADDR_TX_CFG: s_axi_rdata <= {25'h0, tx_cfg_q};
					`SCP_ADDR_RX_CFG: s_axi_rdata <= {25'h0, rx_cfg_q};
					`SCP_ADDR_MSK_IDX: s_axi_rdata <= {28'h0, idx_q};
					`SCP_ADDR_MSK_VAL: s_axi_rdata <= {24'h0, mask_q[idx_q[2:0]]};
					`SCP_ADDR_STATUS: s_axi_rdata <= {16'h0, 3'h0, sh_n_q,
						3'h0, underrun_q, lvl_ext};
					`SCP_ADDR_RX_DATA: s_axi_rdata <= {20'h0, rx_bits_o, rx_field_o};
					`SCP_ADDR_CTRL: s_axi_rdata <= {31'h0, en_q};
					default: begin
						s_axi_rdata <= 32'h0;
						s_axi_rresp <= `SCP_RESP_SLVERR;
					end
				endcase
			end
		end
	end
endmodule

`default_nettype wire

// ==== dv/scp_line_model.sv ====
/*
 * Line-side model: steps its rx byte on each frame strobe; tx bytes are not taken.
 * Assumes the block samples rx between two frame strobes.
 */
`timescale 1ns/1ps
`default_nettype none
module scp_line_model (
	input wire mclk_i, // Clock
	input wire rst_i, // Sync reset
	input wire frame_i, // Tx byte strobe
	output logic [7:0] rx_byte_o // Rx byte to block
);
	// New byte just after each strobe, so it is steady at the next tick
	always @(posedge mclk_i) begin
		if (rst_i) begin
			rx_byte_o <= 8'h5A;
		end else if (frame_i) begin
			rx_byte_o <= {rx_byte_o[6:0], rx_byte_o[7] ^ rx_byte_o[5]} + 8'h13;
		end
	end
endmodule
`default_nettype wire

// ==== dv/scp_subchannel_assertions.sv ====
/*
 * Port-level checker for scp_subchannel, bound to every instance.
 * Assumes a simulation frame period of at least ten clock cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module scp_chk (
	input wire mclk_i, // Clock
	input wire rst_i, // Sync reset
	input wire s_axi_bvalid, // Write resp valid
	input wire s_axi_bready, // Write resp ready
	input wire [1:0] s_axi_bresp, // Write resp
	input wire s_axi_arready, // Read addr ready
	input wire s_axi_rvalid, // Read valid
	input wire s_axi_rready, // Read ready
	input wire [31:0] s_axi_rdata, // Read data
	input wire [7:0] tx_byte_o, // Tx byte
	input wire frame_o, // Frame strobe
	input wire [7:0] rx_field_o, // Rx field
	input wire [3:0] rx_bits_o, // Rx bit count
	input wire rx_valid_o // Rx strobe
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	// Strobes: single cycle, once a frame, tx after rx
	property p_frame_pulse; frame_o |=> !frame_o; endproperty
	a_frame_pulse: assert property (p_frame_pulse) else $error("frame strobe too long");
	property p_rx_gap; rx_valid_o |=> !rx_valid_o [*8]; endproperty
	a_rx_gap: assert property (p_rx_gap) else $error("rx strobe twice in a frame");
	property p_frame_after_rx; rx_valid_o |-> ##[1:6] frame_o; endproperty
	a_frame_after_rx: assert property (p_frame_after_rx) else $error("no tx byte in frame");
	// Outputs only move with their strobe, so the line sees one byte a frame
	property p_tx_hold; $changed(tx_byte_o) |-> frame_o; endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("tx byte moved off frame");
	property p_rx_hold; $changed(rx_field_o) |-> rx_valid_o; endproperty
	a_rx_hold: assert property (p_rx_hold) else $error("rx field moved off strobe");
	property p_bits_range; rx_valid_o |-> rx_bits_o inside {[4'h1:4'h8]}; endproperty
	a_bits_range: assert property (p_bits_range) else $error("rx bit count out of range");
	// Bus answers stand until taken
	property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write resp dropped");
	property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
	property p_ar_answer; s_axi_arready |=> s_axi_rvalid; endproperty
	a_ar_answer: assert property (p_ar_answer) else $error("read answer late");
endmodule
bind scp_subchannel scp_chk u_chk (.mclk_i(mclk_i), .rst_i(rst_i),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata), .tx_byte_o(tx_byte_o), .frame_o(frame_o),
	.rx_field_o(rx_field_o), .rx_bits_o(rx_bits_o), .rx_valid_o(rx_valid_o));
`default_nettype wire

// ==== dv/tb_scp_subchannel.sv ====
/*
 * Self-checking bench for scp_subchannel over AXI4-Lite and the frame link.
 * Assumes a 40-cycle frame and the register map of scp_consts.vh.
 */
`timescale 1ns/1ps
`default_nettype none
`include "scp_consts.vh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin err_total++; $display("ERROR %0t: got %h want %h", $time, a, e); end end
module tb_scp_subchannel;
	logic mclk_i = 0, rst_i = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
	logic [7:0] awa = 0, ara = 0, txb, rxb, rxf, b, e;
	logic [31:0] wd = 0, rd, d;
	logic [2:0] chan = 0;
	logic [6:0] rc = 0;
	logic [23:0] s;
	logic awr, wrd, bv, arr, rv, fr, rxv;
	logic [1:0] br, rr;
	logic [3:0] rxn;
	logic [11:0] last_rx;
	int err_total = 0, n_compared = 0, i;
	scp_subchannel #(.FRAME_CYC(40)) dut (.mclk_i(mclk_i), .rst_i(rst_i),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br),
		.s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
		.s_axi_rready(rre), .tx_chan_i(chan), .rx_byte_i(rxb), .tx_byte_o(txb),
		.frame_o(fr), .rx_field_o(rxf), .rx_bits_o(rxn), .rx_valid_o(rxv));
	scp_line_model u_line (.mclk_i(mclk_i), .rst_i(rst_i), .frame_i(fr), .rx_byte_o(rxb));
	initial begin
		forever #2.5 mclk_i = ~mclk_i;
	end
	//////////////////////////////////////////////////////////////////////////
	// Bus write; both halves offered together, response awaited
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
		int n;
		begin
			n = 0;
			@(posedge mclk_i);
			awa <= a;
			wd <= v;
			awv <= 1;
			wv <= 1;
			bre <= 1;
			do begin
				@(posedge mclk_i);
				if (awr) awv <= 0;
				if (wrd) wv <= 0;
				n++;
			end while (bv !== 1'b1 && n < 500);
			bre <= 0;
			`CHK({n < 500, br}, {1'b1, r})
		end
	endtask
	// Bus read; rready held until the answer
	task automatic rdr(input logic [7:0] a, input logic [1:0] r);
		int n;
		begin
			n = 0;
			@(posedge mclk_i);
			ara <= a;
			arv <= 1;
			rre <= 1;
			do begin
				@(posedge mclk_i);
				if (arr) arv <= 0;
				n++;
			end while (rv !== 1'b1 && n < 500);
			rre <= 0;
			d = rd;
			`CHK({n < 500, rr}, {1'b1, r})
		end
	endtask
	// One frame: rx field from the line byte, then the tx byte
	task automatic frame(input logic [7:0] x);
		int n;
		logic [3:0] k;
		begin
			n = 0;
			do begin @(negedge mclk_i); n++; end while (rxv !== 1'b1 && n < 200);
			k = (rc[2:0] == 3'h0 || rc[6]) ? 4'h8 : {1'b0, rc[2:0]};
			last_rx = {k, (rxb >> rc[5:3]) & (8'hFF >> (4'h8 - k))};
			`CHK({n < 200, rxn, rxf}, {1'b1, last_rx})
			do begin @(negedge mclk_i); n++; end while (fr !== 1'b1 && n < 400);
			`CHK({n < 400, txb}, {1'b1, x})
		end
	endtask
	task automatic stop_test;
		begin
			$display("compared %0d mismatched %0d", n_compared, err_total);
			if (err_total == 0 && n_compared > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	// Watchdog well beyond the roughly 1500 cycles the tests need
	initial begin
		#100000;
		err_total++;
		stop_test;
	end
	initial begin
		repeat (20) @(posedge mclk_i);
		rst_i <= 0;
		// Defaults, unmapped place, separate directions, ignored rx mask
		rdr(`SCP_ADDR_TX_CFG, `SCP_RESP_OKAY);
		`CHK(d, 32'h0)
		rdr(8'h20, `SCP_RESP_SLVERR);
		wr(8'h20, 32'h1, `SCP_RESP_SLVERR);
		wr(`SCP_ADDR_TX_CFG, 32'h4B, `SCP_RESP_OKAY);
		wr(`SCP_ADDR_RX_CFG, 32'h48, `SCP_RESP_OKAY);
		rdr(`SCP_ADDR_TX_CFG, `SCP_RESP_OKAY);
		`CHK(d, 32'h4B)
		rdr(`SCP_ADDR_RX_CFG, `SCP_RESP_OKAY);
		`CHK(d, 32'h48)
		wr(`SCP_ADDR_MSK_IDX, 32'h1, `SCP_RESP_OKAY);
		wr(`SCP_ADDR_MSK_VAL, 32'hB0, `SCP_RESP_OKAY);
		wr(`SCP_ADDR_MSK_IDX, 32'h9, `SCP_RESP_OKAY);
		wr(`SCP_ADDR_MSK_VAL, 32'h0, `SCP_RESP_OKAY);
		$display("register test done");
		chan <= 3'h1;
		rc = 7'h48;
		// Transparent: fill the buffer, then drain it frame by frame
		b = 8'h00;
		for (i = 0; i < 8; i++) begin
			wr(`SCP_ADDR_TX_DATA, {24'h0, b}, `SCP_RESP_OKAY);
			b = b + 8'h25;
		end
		rdr(`SCP_ADDR_STATUS, `SCP_RESP_OKAY);
		`CHK(d[3:0], 4'h8)
		wr(`SCP_ADDR_CTRL, 32'h1, `SCP_RESP_OKAY);
		b = 8'h00;
		for (i = 0; i < 8; i++) begin
			frame(8'hB0 | {4'h0, b[2:0], 1'b0});
			b = b + 8'h25;
		end
		wr(`SCP_ADDR_CTRL, 32'h0, `SCP_RESP_OKAY);
		rdr(`SCP_ADDR_STATUS, `SCP_RESP_OKAY);
		`CHK(d[4:0], 5'h00)
		$display("transparent test done");
		// HDLC: three bits at bit 3, bytes spread over eight frames
		wr(`SCP_ADDR_TX_CFG, 32'h1B, `SCP_RESP_OKAY);
		wr(`SCP_ADDR_RX_CFG, 32'h1B, `SCP_RESP_OKAY);
		wr(`SCP_ADDR_MSK_IDX, 32'h7, `SCP_RESP_OKAY);
		wr(`SCP_ADDR_MSK_VAL, 32'hB3, `SCP_RESP_OKAY);
		chan <= 3'h7;
		rc = 7'h1B;
		s = 24'hF03CA5;
		for (i = 0; i < 3; i++)
			wr(`SCP_ADDR_TX_DATA, {24'h0, s[8 * i +: 8]}, `SCP_RESP_OKAY);
		wr(`SCP_ADDR_CTRL, 32'h1, `SCP_RESP_OKAY);
		for (i = 0; i < 8; i++)
			frame(8'h83 | {2'h0, s[3 * i +: 3], 3'h0});
		wr(`SCP_ADDR_CTRL, 32'h0, `SCP_RESP_OKAY);
		// Count zero: whole byte each way
		wr(`SCP_ADDR_TX_CFG, 32'h0, `SCP_RESP_OKAY);
		wr(`SCP_ADDR_RX_CFG, 32'h0, `SCP_RESP_OKAY);
		rc = 7'h0;
		wr(`SCP_ADDR_TX_DATA, 32'hC6, `SCP_RESP_OKAY);
		wr(`SCP_ADDR_CTRL, 32'h1, `SCP_RESP_OKAY);
		frame(8'hC6);
		$display("hdlc test done");
		// Single-bit field at every start position
		for (i = 0; i < 8; i++) begin
			wr(`SCP_ADDR_CTRL, 32'h0, `SCP_RESP_OKAY);
			wr(`SCP_ADDR_TX_CFG, 32'h41 | (i << 3), `SCP_RESP_OKAY);
			rc = 7'h40 | (i << 3);
			wr(`SCP_ADDR_RX_CFG, {25'h0, rc}, `SCP_RESP_OKAY);
			wr(`SCP_ADDR_TX_DATA, {31'h2A, ~i[0]}, `SCP_RESP_OKAY);
			wr(`SCP_ADDR_CTRL, 32'h1, `SCP_RESP_OKAY);
			e = 8'h01 << i;
			frame((8'hB3 & ~e) | (i[0] ? 8'h00 : e));
		end
		$display("single bit test done");
		// Empty buffer: field goes out as zero and the underrun flag sticks
		frame(8'h33);
		wr(`SCP_ADDR_CTRL, 32'h0, `SCP_RESP_OKAY);
		rdr(`SCP_ADDR_STATUS, `SCP_RESP_OKAY);
		`CHK(d[4:0], 5'h10)
		rdr(`SCP_ADDR_RX_DATA, `SCP_RESP_OKAY);
		`CHK(d, {20'h0, last_rx})
		rdr(`SCP_ADDR_MSK_VAL, `SCP_RESP_OKAY);
		`CHK(d, 32'hB3)
		$display("underrun test done");
		stop_test;
	end
endmodule
`default_nettype wire
